//--- rtl/mbcfg_bank.v
// Microphone bias and channel one input configuration register bank
`timescale 1ns/1ps
`include "mbcfg_defs.vh"
module mbcfg_bank (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Control port register access, already decoded from the serial interface
    input wire [7:0] reg_page,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire reg_rd_en,
    output reg [7:0] reg_rdata_r,
    output reg reg_rvalid_r,
    output wire reg_hit,
    // Mode bit of the automatic level setup register, held elsewhere
    input wire auto_level_mode_in,
    // Microphone bias settings
    output wire [3:0] bias_level_code,
    output reg [4:0] microphone_supply_r,
    output reg bias_level_reserved_r,
    output wire [1:0] bias_spare_bits,
    // Channel one input settings
    output wire ch_one_source_kind,
    output wire [1:0] ch_one_input_wiring,
    output wire ch_one_coupling_select,
    output wire ch_one_swing_select,
    output wire [1:0] ch_one_amp_tradeoff,
    output wire ch_one_auto_level_on,
    output reg ch_one_single_ended_r,
    output reg ch_one_high_cmrr_r,
    output reg ch_one_wiring_reserved_r,
    output reg ch_one_amp_reserved_r,
    // Automatic level control request and misuse flag
    output reg auto_level_run_r,
    output reg auto_level_mode_r,
    output reg auto_level_dc_conflict_r,
    // Channel one gain settings
    output wire [5:0] ch_one_gain_code,
    output wire ch_one_gain_spare,
    output reg ch_one_gain_reserved_r
);

    wire page_ok;
    wire sel_bias;
    wire sel_in;
    wire sel_gain;
    wire [7:0] bias_value;
    wire [7:0] in_value;
    wire [7:0] gain_value;
    reg [7:0] rd_mux;

    // Address decode; only page 0 holds this bank
    assign page_ok = (reg_page == `MBCFG_PAGE0);
    assign sel_bias = page_ok && (reg_addr == `MBCFG_ADDR_BIAS);
    assign sel_in = page_ok && (reg_addr == `MBCFG_ADDR_CH1_IN);
    assign sel_gain = page_ok && (reg_addr == `MBCFG_ADDR_CH1_GAIN);
    assign reg_hit = sel_bias || sel_in || sel_gain;

    // Bias setup: level nibble and spare pair store, bits 3 to 2 stay zero
    mbcfg_reg8 #(
        .RESET_VAL(`MBCFG_RST_BIAS),
        .WMASK(`MBCFG_WMASK_BIAS)
    ) u_bias (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(reg_wr_en && sel_bias),
        .wdata(reg_wdata),
        .value_r(bias_value)
    );

    // Channel one input setup, every bit writable
    mbcfg_reg8 #(
        .RESET_VAL(`MBCFG_RST_CH1_IN),
        .WMASK(`MBCFG_WMASK_CH1_IN)
    ) u_ch1_in (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(reg_wr_en && sel_in),
        .wdata(reg_wdata),
        .value_r(in_value)
    );

    // Channel one gain setup; bit 0 reads as zero
    mbcfg_reg8 #(
        .RESET_VAL(`MBCFG_RST_CH1_GAIN),
        .WMASK(`MBCFG_WMASK_CH1_GAIN)
    ) u_ch1_gain (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_en(reg_wr_en && sel_gain),
        .wdata(reg_wdata),
        .value_r(gain_value)
    );

    // Field outputs straight from the register flops
    assign bias_level_code = bias_value[`MBCFG_BIAS_LVL_HI:`MBCFG_BIAS_LVL_LO];
    assign bias_spare_bits = bias_value[`MBCFG_BIAS_SPARE_HI:`MBCFG_BIAS_SPARE_LO];
    assign ch_one_source_kind = in_value[`MBCFG_IN_KIND_BIT];
    assign ch_one_input_wiring = in_value[`MBCFG_IN_WIRE_HI:`MBCFG_IN_WIRE_LO];
    assign ch_one_coupling_select = in_value[`MBCFG_IN_COUPLE_BIT];
    assign ch_one_swing_select = in_value[`MBCFG_IN_SWING_BIT];
    assign ch_one_amp_tradeoff = in_value[`MBCFG_IN_AMP_HI:`MBCFG_IN_AMP_LO];
    assign ch_one_auto_level_on = in_value[`MBCFG_IN_ALC_BIT];
    assign ch_one_gain_code = gain_value[`MBCFG_GAIN_HI:`MBCFG_GAIN_LO];
    assign ch_one_gain_spare = gain_value[`MBCFG_GAIN_LO - 1];

    // Read multiplexer; unmapped addresses answer zero
    always @* begin
        if (sel_bias) begin
            rd_mux = bias_value;
        end else if (sel_in) begin
            rd_mux = in_value;
        end else if (sel_gain) begin
            rd_mux = gain_value;
        end else begin
            rd_mux = `MBCFG_RD_NONE;
        end
    end

    // Read answer one cycle after the strobe; a same-cycle write is not yet seen
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata_r <= `MBCFG_RD_NONE;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

    // Decoded bias supply in half volts; reserved codes drive zero, not a guess
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            microphone_supply_r <= 5'h00;
            bias_level_reserved_r <= 1'b0;
        end else if (bias_level_code < `MBCFG_BIAS_MIN_CODE) begin
            microphone_supply_r <= 5'h00;
            bias_level_reserved_r <= 1'b1;
        end else begin
            microphone_supply_r <= {1'b0, bias_level_code} + `MBCFG_BIAS_HALFV_OFS;
            bias_level_reserved_r <= 1'b0;
        end
    end

    // Decoded input wiring and amplifier mode, with reserved-code flags
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ch_one_single_ended_r <= 1'b0;
            ch_one_high_cmrr_r <= 1'b0;
            ch_one_wiring_reserved_r <= 1'b0;
            ch_one_amp_reserved_r <= 1'b0;
        end else begin
            ch_one_single_ended_r <= (ch_one_input_wiring == `MBCFG_WIRE_SE);
            ch_one_wiring_reserved_r <= (ch_one_input_wiring != `MBCFG_WIRE_SE) &&
                (ch_one_input_wiring != `MBCFG_WIRE_DIFF);
            ch_one_high_cmrr_r <= (ch_one_amp_tradeoff == `MBCFG_AMP_CMRR);
            ch_one_amp_reserved_r <= (ch_one_amp_tradeoff != `MBCFG_AMP_CMRR) &&
                (ch_one_amp_tradeoff != `MBCFG_AMP_SNR);
        end
    end

    // Level control request follows the enable; the mode bit is only passed on.
    // Enabling it on a DC-coupled input is flagged, not blocked, so software sees it.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            auto_level_run_r <= 1'b0;
            auto_level_mode_r <= 1'b0;
            auto_level_dc_conflict_r <= 1'b0;
            ch_one_gain_reserved_r <= 1'b0;
        end else begin
            auto_level_run_r <= ch_one_auto_level_on;
            auto_level_mode_r <= auto_level_mode_in;
            auto_level_dc_conflict_r <= ch_one_auto_level_on &&
                (ch_one_coupling_select != `MBCFG_COUPLE_AC);
            ch_one_gain_reserved_r <= (ch_one_gain_code > `MBCFG_GAIN_MAX);
        end
    end

endmodule

//--- rtl/mbcfg_defs.vh
// Constants for the microphone bias and channel one input configuration bank
// Operation
// - Bias level nibble selects 5 V at code 7 to 9 V at 15.
// - Bias level field resets to code 13, an 8 V bias.
// - Bias setup register is page 0 address 3B, resets to D0.
// - Channel one input setup register is page 0 address 3C, resets to 10.
// - Bit 7 picks microphone input at zero, line input at one.
// - Bits 6 to 5 pick differential or single-ended wiring; 2, 3 reserved.
// - Bit 4 picks AC coupling at zero, DC at one; resets to one.
// - Bit 3 cleared selects low swing input range.
// - Bits 2 to 1 pick high SNR or high CMRR mode.
// - Bit 0 enables automatic level control, following the external mode bit.
// - Channel one gain setup register is page 0 address 3D, resets to 0.
`ifndef MBCFG_DEFS_VH
`define MBCFG_DEFS_VH

// Register placement
`define MBCFG_PAGE0 8'h00
`define MBCFG_ADDR_BIAS 8'h3B
`define MBCFG_ADDR_CH1_IN 8'h3C
`define MBCFG_ADDR_CH1_GAIN 8'h3D

// Whole-byte reset values
`define MBCFG_RST_BIAS 8'hD0
`define MBCFG_RST_CH1_IN 8'h10
`define MBCFG_RST_CH1_GAIN 8'h00

// Writable bit masks; cleared bits read as zero
`define MBCFG_WMASK_BIAS 8'hF3
`define MBCFG_WMASK_CH1_IN 8'hFF
`define MBCFG_WMASK_CH1_GAIN 8'hFE

// Read answer for unmapped addresses
`define MBCFG_RD_NONE 8'h00

// Bias setup fields
`define MBCFG_BIAS_LVL_HI 7
`define MBCFG_BIAS_LVL_LO 4
`define MBCFG_BIAS_SPARE_HI 1
`define MBCFG_BIAS_SPARE_LO 0
`define MBCFG_BIAS_MIN_CODE 4'h7
`define MBCFG_BIAS_HALFV_OFS 5'h03

// Channel one input setup fields
`define MBCFG_IN_KIND_BIT 7
`define MBCFG_IN_WIRE_HI 6
`define MBCFG_IN_WIRE_LO 5
`define MBCFG_IN_COUPLE_BIT 4
`define MBCFG_IN_SWING_BIT 3
`define MBCFG_IN_AMP_HI 2
`define MBCFG_IN_AMP_LO 1
`define MBCFG_IN_ALC_BIT 0

// Field codes
`define MBCFG_WIRE_DIFF 2'h0
`define MBCFG_WIRE_SE 2'h1
`define MBCFG_AMP_SNR 2'h0
`define MBCFG_AMP_CMRR 2'h2
`define MBCFG_COUPLE_AC 1'h0

// Channel one gain setup fields
`define MBCFG_GAIN_HI 7
`define MBCFG_GAIN_LO 2
`define MBCFG_GAIN_MAX 6'h2A

`endif

//--- rtl/mbcfg_reg8.v
// One byte configuration register with per-bit write mask and reset value
`timescale 1ns/1ps
module mbcfg_reg8 #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WMASK = 8'hFF
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Write side
    input wire wr_en,
    input wire [7:0] wdata,
    // Stored value
    output reg [7:0] value_r
);

    reg [7:0] value_nxt;

    // Masked bits keep their reset value, which is zero for read-only bits
    always @* begin
        value_nxt = value_r;
        if (wr_en) begin
            value_nxt = (wdata & WMASK) | (value_r & ~WMASK);
        end
    end

    // Synchronous active-low reset
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            value_r <= RESET_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule

//--- verification/mbcfg_bank_properties.sv
// Port timing checker for the bias and channel one config bank
`timescale 1ns/1ps
module mbcfg_bank_properties (
    // Clock and reset
    input logic clk_sys,
    input logic reset_n,
    // Register port
    input logic reg_rd_en,
    input logic reg_rvalid_r,
    input logic [7:0] reg_rdata_r,
    input logic reg_hit,
    // Decoded settings
    input logic [3:0] bias_level_code,
    input logic [4:0] microphone_supply_r,
    input logic [1:0] ch_one_amp_tradeoff,
    input logic ch_one_high_cmrr_r,
    input logic ch_one_auto_level_on,
    input logic auto_level_run_r,
    input logic auto_level_mode_in,
    input logic auto_level_mode_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Read answer comes exactly one cycle after the strobe
    chk_rvalid_pulse: assert property (reg_rd_en |=> reg_rvalid_r)
        else $error("read valid missing after read strobe");
    chk_rvalid_cause: assert property (reg_rvalid_r |-> $past(reg_rd_en))
        else $error("read valid without a read");
    chk_unmapped_zero: assert property (reg_rd_en && !reg_hit |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");
    // Bias code to half-volt units, five volts at the lowest legal code
    chk_supply_map: assert property (bias_level_code >= 4'h7 |=>
        microphone_supply_r == $past({1'b0, bias_level_code}) + 5'h03)
        else $error("bias supply decode wrong");
    chk_supply_resv: assert property (bias_level_code < 4'h7 |=> microphone_supply_r == 5'h00)
        else $error("reserved bias code gave a supply");
    chk_cmrr_flag: assert property (1'b1 |=>
        ch_one_high_cmrr_r == $past(ch_one_amp_tradeoff == 2'h2))
        else $error("high cmrr flag wrong");
    chk_alc_follow: assert property (1'b1 |=> auto_level_run_r == $past(ch_one_auto_level_on)
        && auto_level_mode_r == $past(auto_level_mode_in))
        else $error("auto level request not following setup");
    cover property (reg_rd_en && !reg_hit);
    cover property (bias_level_code == 4'h7);
    cover property (auto_level_run_r && auto_level_mode_r);
endmodule
bind mbcfg_bank mbcfg_bank_properties mbcfg_bank_properties_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_rd_en(reg_rd_en), .reg_rvalid_r(reg_rvalid_r),
    .reg_rdata_r(reg_rdata_r), .reg_hit(reg_hit), .bias_level_code(bias_level_code),
    .microphone_supply_r(microphone_supply_r), .ch_one_amp_tradeoff(ch_one_amp_tradeoff),
    .ch_one_high_cmrr_r(ch_one_high_cmrr_r), .ch_one_auto_level_on(ch_one_auto_level_on),
    .auto_level_run_r(auto_level_run_r), .auto_level_mode_in(auto_level_mode_in),
    .auto_level_mode_r(auto_level_mode_r));

//--- verification/mbcfg_bank_tb.sv
// Self-checking bench for the bias and channel one config bank
`timescale 1ns/1ps
module mbcfg_bank_tb;
    logic clk_sys, reset_n, wen, ren, alm, rvl, kind, cpl, swg, alc, gsp, conf;
    logic hit, brs, sng, cmr, wrs, ars, run, mod, grs;
    logic [7:0] pg, adr, wd, rdt, rd_v;
    logic [3:0] blc;
    logic [4:0] sup;
    logic [1:0] bsp, wir, amp;
    logic [5:0] gc;
    // Expected supply and decoded bits, address, write byte, expected readback.
    // Legal codes only, level control only on AC inputs, gain set after high swing.
    logic [31:0] rows [8] = '{32'h903BFFF3, 32'h503B7070, 32'h583B8F83, 32'h5F3CA5A5,
        32'h593C8181, 32'h5C3C3838, 32'h5C3DABAA, 32'h5C3E5500};
    int fails = 0;
    int num_checks = 0;
    mbcfg_bank mbcfg_bank_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_page(pg),
        .reg_addr(adr), .reg_wr_en(wen), .reg_wdata(wd), .reg_rd_en(ren),
        .reg_rdata_r(rdt), .reg_rvalid_r(rvl), .reg_hit(hit), .auto_level_mode_in(alm),
        .bias_level_code(blc), .microphone_supply_r(sup), .bias_level_reserved_r(brs),
        .bias_spare_bits(bsp), .ch_one_source_kind(kind), .ch_one_input_wiring(wir),
        .ch_one_coupling_select(cpl), .ch_one_swing_select(swg), .ch_one_amp_tradeoff(amp),
        .ch_one_auto_level_on(alc), .ch_one_single_ended_r(sng), .ch_one_high_cmrr_r(cmr),
        .ch_one_wiring_reserved_r(wrs), .ch_one_amp_reserved_r(ars), .auto_level_run_r(run),
        .auto_level_mode_r(mod), .auto_level_dc_conflict_r(conf), .ch_one_gain_code(gc),
        .ch_one_gain_spare(gsp), .ch_one_gain_reserved_r(grs));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Strobes rise and fall on falling edges, taken on the rising edge between
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        pg = p;
        adr = a;
        wd = d;
        wen = 1'b1;
        @(negedge clk_sys);
        wen = 1'b0;
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] a);
        @(negedge clk_sys);
        pg = p;
        adr = a;
        ren = 1'b1;
        @(negedge clk_sys);
        ren = 1'b0;
        chk("rvalid", {7'h00, rvl}, 8'h01);
        rd_v = rdt;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // A few hundred cycles at most are expected
    initial begin
        #5000;
        fails++;
        complete_run();
    end
    initial begin
        {reset_n, wen, ren, alm} = 4'h0;
        {pg, adr, wd} = 24'h000000;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        rd(8'h00, 8'h3B);
        chk("bias", rd_v, 8'hD0);
        rd(8'h00, 8'h3C);
        chk("ch1in", rd_v, 8'h10);
        rd(8'h00, 8'h3D);
        chk("gain", rd_v, 8'h00);
        chk("supply", {3'h0, sup}, 8'h10);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            alm = i[0];
            wr(8'h00, rows[i][23:16], rows[i][15:8]);
            rd(8'h00, rows[i][23:16]);
            chk("rdata", rd_v, rows[i][7:0]);
            chk("derived", {sup, sng, cmr, run}, rows[i][31:24]);
            chk("flags", {2'h0, mod, hit, brs, wrs, ars, grs},
                {2'h0, i[0], rows[i][23:16] != 8'h3E, 4'h0});
            if (rows[i][23:16] == 8'h3D)
                chk("gainf", {gc, gsp, 1'b0}, rows[i][7:0]);
            if (rows[i][23:16] == 8'h3C)
                chk("fields", {kind, wir, cpl, swg, amp, alc}, rows[i][7:0]);
            if (rows[i][23:16] == 8'h3B)
                chk("biasf", {blc, 2'h0, bsp}, rows[i][7:0]);
        end
        $display("row test done");
        // Reserved codes on purpose: stored apart from the read-only bits, flagged, no supply decoded
        wr(8'h00, 8'h3B, 8'h0F);
        wr(8'h00, 8'h3C, 8'h5A);
        wr(8'h00, 8'h3D, 8'hFF);
        rd(8'h00, 8'h3D);
        chk("gainrsv", rd_v, 8'hFE);
        chk("rsvsup", {3'h0, sup}, 8'h00);
        chk("rsvflags", {4'h0, brs, wrs, ars, grs}, 8'h0F);
        $display("reserved test done");
        // Other page must neither store nor answer
        wr(8'h01, 8'h3B, 8'hF0);
        rd(8'h00, 8'h3B);
        chk("page", rd_v, 8'h03);
        rd(8'h01, 8'h3B);
        chk("page1", rd_v, 8'h00);
        // Read in the same cycle as a write returns the old byte
        @(negedge clk_sys);
        pg = 8'h00;
        adr = 8'h3B;
        wd = 8'hA1;
        wen = 1'b1;
        ren = 1'b1;
        @(negedge clk_sys);
        wen = 1'b0;
        ren = 1'b0;
        chk("old", rdt, 8'h03);
        rd(8'h00, 8'h3B);
        chk("new", rd_v, 8'hA1);
        // Auto level on a DC input is flagged
        wr(8'h00, 8'h3C, 8'h11);
        @(negedge clk_sys);
        chk("conflict", {7'h00, conf}, 8'h01);
        $display("edge test done");
        // Mid-run reset must bring the input and bias bytes and the decoded bias back
        @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        rd(8'h00, 8'h3C);
        chk("rst_in", rd_v, 8'h10);
        rd(8'h00, 8'h3B);
        chk("rst_bias", rd_v, 8'hD0);
        chk("rst_sup", {3'h0, sup}, 8'h10);
        chk("rst_conf", {7'h00, conf}, 8'h00);
        $display("reset again done");
        complete_run();
    end
endmodule
